// ==== exm_consts.vh ====
// Constants for the expansion and serial link monitor.
`ifndef EXM_CONSTS_VH
`define EXM_CONSTS_VH

// Clock rate in kHz, used to turn milliseconds into cycles.
`define EXM_CLK_KHZ 100000

// Register byte offsets on the Avalon-MM slave.
`define EXM_REG_CTRL 8'h00
`define EXM_REG_STATUS 8'h04
`define EXM_REG_EXP_IN 8'h08
`define EXM_REG_EXP_OUT 8'h0C
`define EXM_REG_LINK_RX 8'h10
`define EXM_REG_MFI_COUNT 8'h14

// Control register fields.
`define EXM_CTRL_RUN_REQ 0
`define EXM_CTRL_REMOTE_EXP 1
`define EXM_CTRL_LINK_EN 2
`define EXM_CTRL_LINK_BAUD 3
`define EXM_CTRL_EXP_USED 4
`define EXM_CTRL_MFI_BAUD_LO 5
`define EXM_CTRL_MFI_BAUD_HI 6
`define EXM_CTRL_RESET 7'h00

// Status register fields.
`define EXM_ST_BASE_FAULT 0
`define EXM_ST_EXP_FAULT_1_4 1
`define EXM_ST_EXP_FAULT_5_8 2
`define EXM_ST_EXP_NOT_FUNC 3
`define EXM_ST_LINK_DIAG 4
`define EXM_ST_CONFLICT 5
`define EXM_ST_RUN 6
`define EXM_ST_MFI_BUSY 7

// Expansion transfer times in ms.
`define EXM_T_EXP_IN_LOCAL_MS 30
`define EXM_T_EXP_OUT_LOCAL_MS 15
`define EXM_T_EXP_IN_REMOTE_MS 80
`define EXM_T_EXP_OUT_REMOTE_MS 40

// Multi-function interface timeouts in ms, per baud rate code 0..3.
`define EXM_T_MFI_9K6_MS 4000
`define EXM_T_MFI_19K2_MS 3200
`define EXM_T_MFI_38K4_MS 2400
`define EXM_T_MFI_57K6_MS 2000

// Peer link diagnostic delays in ms.
`define EXM_T_CRC_9K6_MS 250
`define EXM_T_CRC_19K2_MS 120
`define EXM_T_NORESP_9K6_MS 1500
`define EXM_T_NORESP_19K2_MS 800

`endif

// ==== exm_monitor.v ====
// Expansion, serial interface and peer link supervision with an Avalon-MM register slave.
`timescale 1ns/1ns
`default_nettype none
`include "exm_consts.vh"
module exm_monitor #(
    parameter TRANSISTOR_OUTPUTS = 1,
    parameter CLK_KHZ = `EXM_CLK_KHZ, // Clock cycles per millisecond.
    parameter EXP_IN_LOCAL_CYC = `EXM_T_EXP_IN_LOCAL_MS * CLK_KHZ,
    parameter EXP_OUT_LOCAL_CYC = `EXM_T_EXP_OUT_LOCAL_MS * CLK_KHZ,
    parameter EXP_IN_REMOTE_CYC = `EXM_T_EXP_IN_REMOTE_MS * CLK_KHZ,
    parameter EXP_OUT_REMOTE_CYC = `EXM_T_EXP_OUT_REMOTE_MS * CLK_KHZ,
    parameter MFI_9K6_CYC = `EXM_T_MFI_9K6_MS * CLK_KHZ,
    parameter MFI_19K2_CYC = `EXM_T_MFI_19K2_MS * CLK_KHZ,
    parameter MFI_38K4_CYC = `EXM_T_MFI_38K4_MS * CLK_KHZ,
    parameter MFI_57K6_CYC = `EXM_T_MFI_57K6_MS * CLK_KHZ,
    parameter CRC_9K6_CYC = `EXM_T_CRC_9K6_MS * CLK_KHZ,
    parameter CRC_19K2_CYC = `EXM_T_CRC_19K2_MS * CLK_KHZ,
    parameter NORESP_9K6_CYC = `EXM_T_NORESP_9K6_MS * CLK_KHZ,
    parameter NORESP_19K2_CYC = `EXM_T_NORESP_19K2_MS * CLK_KHZ
) (
    // Clock and reset.
    input wire clock,
    input wire rstn,
    // Avalon-MM slave.
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Base transistor output fault sensing.
    input wire [3:0] base_transistor_output,
    output wire base_output_group_fault,
    // Expansion link, received image.
    input wire exp_rx_valid,
    input wire [11:0] exp_rx_inputs,
    input wire exp_rx_fault_1_4,
    input wire exp_rx_fault_5_8,
    // Expansion link, transmitted image.
    output reg exp_tx_valid,
    output reg [7:0] exp_tx_coils,
    // Expansion state.
    output wire expansion_not_functional,
    // Serial multi-function interface.
    input wire mfi_start,
    input wire mfi_char_valid,
    input wire mfi_end,
    output reg mfi_discard,
    // Peer station link.
    input wire link_frame_ok,
    input wire link_crc_error,
    input wire [15:0] link_rx_data,
    output reg link_start_req,
    output wire peer_link_diag_bit,
    // Module conflict and run mode.
    input wire module_conflict_diag,
    output wire run_mode
);

    // ****************************************************************
    // Local definitions
    // ****************************************************************
    localparam MFI_IDLE = 1'b0;
    localparam MFI_BUSY = 1'b1;
    // Picks the stall timeout of the multi-function interface by baud code.
    function [31:0] mfi_limit;
        input [1:0] baud;
        begin
            case (baud)
                2'h0: mfi_limit = MFI_9K6_CYC;
                2'h1: mfi_limit = MFI_19K2_CYC;
                2'h2: mfi_limit = MFI_38K4_CYC;
                2'h3: mfi_limit = MFI_57K6_CYC;
                default: mfi_limit = MFI_9K6_CYC;
            endcase
        end
    endfunction
    // Picks one of two cycle counts by a select bit.
    function [31:0] pick;
        input sel;
        input [31:0] when_low;
        input [31:0] when_high;
        begin
            pick = sel ? when_high : when_low;
        end
    endfunction

    reg rst_meta;
    reg rst_sync;
    reg [6:0] ctrl;
    reg [7:0] exp_out;
    reg bus_ack;
    reg exp_connected;
    reg [31:0] exp_age;
    reg [31:0] exp_tx_timer;
    reg [11:0] exp_in;
    reg exp_f14;
    reg exp_f58;
    reg mfi_state;
    reg [31:0] mfi_timer;
    reg [15:0] mfi_count;
    reg link_diag;
    reg crc_pending;
    reg [31:0] crc_timer;
    reg [31:0] resp_timer;
    reg [15:0] link_rx;
    reg [31:0] next_readdata;
    wire link_en;
    wire link_fast;
    wire [31:0] exp_in_limit;
    wire [31:0] exp_out_limit;
    wire [31:0] crc_limit;
    wire [31:0] resp_limit;
    wire [7:0] status;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    // Releases the asynchronous reset through two flip-flops.
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ****************************************************************
    // Fault flags and status
    // ****************************************************************

    // Relay variants have no fault sensing, so the flags stay at zero.
    assign base_output_group_fault = (TRANSISTOR_OUTPUTS != 0) &&
                                     (|base_transistor_output);
    assign expansion_not_functional = !exp_connected;
    assign run_mode = ctrl[`EXM_CTRL_RUN_REQ] && !module_conflict_diag;
    assign peer_link_diag_bit = link_diag;
    assign link_en = ctrl[`EXM_CTRL_LINK_EN];
    assign link_fast = ctrl[`EXM_CTRL_LINK_BAUD];
    assign exp_in_limit = pick(ctrl[`EXM_CTRL_REMOTE_EXP], EXP_IN_LOCAL_CYC,
                               EXP_IN_REMOTE_CYC);
    assign exp_out_limit = pick(ctrl[`EXM_CTRL_REMOTE_EXP], EXP_OUT_LOCAL_CYC,
                                EXP_OUT_REMOTE_CYC);
    assign crc_limit = pick(link_fast, CRC_9K6_CYC, CRC_19K2_CYC);
    assign resp_limit = pick(link_fast, NORESP_9K6_CYC, NORESP_19K2_CYC);

    // Collects the block state shown in the status register.
    assign status = {mfi_state, run_mode, module_conflict_diag, link_diag,
                     expansion_not_functional, exp_f58, exp_f14,
                     base_output_group_fault};

    // ****************************************************************
    // Avalon-MM slave
    // ****************************************************************

    // Every access waits exactly one cycle, then completes.
    assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

    // Selects read data; unmapped offsets read as zero.
    always @* begin
        case (avs_address)
            `EXM_REG_CTRL: next_readdata = {25'h000_0000, ctrl};
            `EXM_REG_STATUS: next_readdata = {24'h00_0000, status};
            `EXM_REG_EXP_IN: next_readdata = {20'h0_0000, exp_in};
            `EXM_REG_EXP_OUT: next_readdata = {24'h00_0000, exp_out};
            `EXM_REG_LINK_RX: next_readdata = {16'h0000, link_rx};
            `EXM_REG_MFI_COUNT: next_readdata = {16'h0000, mfi_count};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // Registers read data in the first cycle; a write lands at the completing edge.
    always @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            bus_ack <= 1'b0;
            ctrl <= `EXM_CTRL_RESET;
            exp_out <= 8'h00;
            avs_readdata <= 32'h0000_0000;
        end else begin
            bus_ack <= (avs_read || avs_write) && !bus_ack;
            if (avs_read && !bus_ack) begin
                avs_readdata <= next_readdata;
            end
            if (avs_write && bus_ack) begin
                case (avs_address)
                    `EXM_REG_CTRL: ctrl <= avs_writedata[6:0];
                    `EXM_REG_EXP_OUT: exp_out <= avs_writedata[7:0];
                    default: ctrl <= ctrl;
                endcase
            end
        end
    end

    // ****************************************************************
    // Expansion link
    // ****************************************************************

    // Tracks the input image and drops the connection when frames stop.
    // Inputs are taken straight from the link with no debounce.
    always @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            exp_connected <= 1'b0;
            exp_age <= 32'h0000_0000;
            exp_in <= 12'h000;
            exp_f14 <= 1'b0;
            exp_f58 <= 1'b0;
        end else if (!ctrl[`EXM_CTRL_EXP_USED]) begin
            exp_connected <= 1'b0;
            exp_age <= 32'h0000_0000;
            exp_in <= 12'h000;
            exp_f14 <= 1'b0;
            exp_f58 <= 1'b0;
        end else if (exp_rx_valid) begin
            exp_connected <= 1'b1;
            exp_age <= 32'h0000_0000;
            exp_in <= exp_rx_inputs;
            exp_f14 <= exp_rx_fault_1_4 && (TRANSISTOR_OUTPUTS != 0);
            exp_f58 <= exp_rx_fault_5_8 && (TRANSISTOR_OUTPUTS != 0);
        end else if (exp_age >= exp_in_limit - 32'h1) begin
            exp_connected <= 1'b0;
            exp_in <= 12'h000;
            exp_f14 <= 1'b0;
            exp_f58 <= 1'b0;
        end else begin
            exp_age <= exp_age + 32'h1;
        end
    end

    // Sends the coil image once per output period; zeros while unconnected.
    always @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            exp_tx_timer <= 32'h0000_0000;
            exp_tx_valid <= 1'b0;
            exp_tx_coils <= 8'h00;
        end else begin
            exp_tx_valid <= 1'b0;
            if (!ctrl[`EXM_CTRL_EXP_USED]) begin
                exp_tx_timer <= 32'h0000_0000;
                exp_tx_coils <= 8'h00;
            end else if (exp_tx_timer >= exp_out_limit - 32'h1) begin
                exp_tx_timer <= 32'h0000_0000;
                exp_tx_valid <= 1'b1;
                exp_tx_coils <= exp_connected ? exp_out : 8'h00;
            end else begin
                exp_tx_timer <= exp_tx_timer + 32'h1;
            end
        end
    end

    // ****************************************************************
    // Multi-function interface supervision
    // ****************************************************************

    // Counts characters of an exchange and discards it when it stalls.
    always @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            mfi_state <= MFI_IDLE;
            mfi_timer <= 32'h0000_0000;
            mfi_count <= 16'h0000;
            mfi_discard <= 1'b0;
        end else begin
            mfi_discard <= 1'b0;
            case (mfi_state)
                MFI_IDLE: begin
                    mfi_timer <= 32'h0000_0000;
                    if (mfi_start) begin
                        mfi_state <= MFI_BUSY;
                        mfi_count <= 16'h0000;
                    end
                end
                MFI_BUSY: begin
                    if (mfi_end) begin
                        mfi_state <= MFI_IDLE;
                    end else if (mfi_char_valid) begin
                        mfi_timer <= 32'h0000_0000;
                        mfi_count <= mfi_count + 16'h1;
                    end else if (mfi_timer >= mfi_limit({ctrl[`EXM_CTRL_MFI_BAUD_HI],
                                 ctrl[`EXM_CTRL_MFI_BAUD_LO]}) - 32'h1) begin
                        mfi_state <= MFI_IDLE;
                        mfi_count <= 16'h0000;
                        mfi_discard <= 1'b1;
                    end else begin
                        mfi_timer <= mfi_timer + 32'h1;
                    end
                end
                default: mfi_state <= MFI_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Peer link supervision
    // ****************************************************************

    // Times checksum errors and silence, raises the diagnostic bit,
    // clears the remote-read image and keeps asking for a new exchange.
    always @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            link_diag <= 1'b0;
            crc_pending <= 1'b0;
            crc_timer <= 32'h0000_0000;
            resp_timer <= 32'h0000_0000;
            link_rx <= 16'h0000;
            link_start_req <= 1'b0;
        end else begin
            link_start_req <= 1'b0;
            if (!link_en) begin
                link_diag <= 1'b0;
                crc_pending <= 1'b0;
                crc_timer <= 32'h0000_0000;
                resp_timer <= 32'h0000_0000;
                link_rx <= 16'h0000;
            end else if (link_frame_ok) begin
                link_diag <= 1'b0;
                crc_pending <= 1'b0;
                crc_timer <= 32'h0000_0000;
                resp_timer <= 32'h0000_0000;
                link_rx <= link_rx_data;
            end else begin
                if (link_crc_error) begin
                    crc_pending <= 1'b1;
                    resp_timer <= 32'h0000_0000;
                end else if (resp_timer >= resp_limit - 32'h1) begin
                    resp_timer <= 32'h0000_0000;
                    link_diag <= 1'b1;
                    link_rx <= 16'h0000;
                    link_start_req <= 1'b1;
                end else begin
                    resp_timer <= resp_timer + 32'h1;
                end
                if (crc_pending || link_crc_error) begin
                    if (crc_timer >= crc_limit - 32'h1) begin
                        crc_timer <= 32'h0000_0000;
                        link_diag <= 1'b1;
                        link_rx <= 16'h0000;
                        link_start_req <= 1'b1;
                    end else begin
                        crc_timer <= crc_timer + 32'h1;
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== exm_monitor_props.sv ====
// Concurrent checks on the ports of the expansion and serial link monitor.
`timescale 1ns/1ns
`default_nettype none
module exm_monitor_props (
    // Clock and reset.
    input wire clock,
    input wire rstn,
    // Observed ports.
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire [3:0] base_transistor_output,
    input wire base_output_group_fault,
    input wire exp_rx_valid,
    input wire exp_tx_valid,
    input wire [7:0] exp_tx_coils,
    input wire expansion_not_functional,
    input wire mfi_char_valid,
    input wire mfi_discard,
    input wire link_frame_ok,
    input wire link_start_req,
    input wire peer_link_diag_bit,
    input wire module_conflict_diag,
    input wire run_mode
);
    // ********************
    // Port relations.
    // ********************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_base_fault_or: assert property (base_output_group_fault == |base_transistor_output)
        else $error("base group fault does not follow the outputs");
    a_run_conflict_gate: assert property (run_mode |-> !module_conflict_diag)
        else $error("run mode entered during a module conflict");
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not in the second cycle");
    a_tx_single_pulse: assert property (exp_tx_valid |=> !exp_tx_valid)
        else $error("output image pulse longer than one cycle");
    a_discard_pulse: assert property (mfi_discard |=> !mfi_discard)
        else $error("discard pulse longer than one cycle");
    a_char_restarts_timer: assert property (mfi_char_valid |=> !mfi_discard [*8])
        else $error("discard right after a received character");
    a_frame_clears_diag: assert property (link_frame_ok |=> !peer_link_diag_bit)
        else $error("diagnostic bit set after a good frame");
    a_fault_retry_req: assert property ($rose(peer_link_diag_bit) |->
        (link_start_req || $past(link_start_req)))
        else $error("no retry request with the link fault");
    a_connect_by_frame: assert property ($fell(expansion_not_functional) |-> $past(exp_rx_valid))
        else $error("expansion became functional without a frame");
    a_coils_off_lost: assert property (exp_tx_valid && expansion_not_functional &&
        $past(expansion_not_functional, 2) |-> exp_tx_coils == 8'h00)
        else $error("coils sent while the expansion is lost");
endmodule
`default_nettype wire

// ==== exm_exp_partner.sv ====
// Behavioural expansion unit on the far side of the expansion link.
`timescale 1ns/1ns
`default_nettype none
module exm_exp_partner (
    // Clock.
    input wire logic clock,
    // Settings from the bench.
    input wire logic en,
    input wire logic [7:0] period,
    input wire logic [11:0] img,
    input wire logic [1:0] flt,
    // Input image towards the monitor.
    output logic rx_valid,
    output logic [11:0] rx_inputs,
    output logic [1:0] rx_flt
);
    logic [7:0] cnt;
    // Starts with quiet lines.
    initial begin
        cnt = 8'h00;
        rx_valid = 1'b0;
        rx_inputs = 12'h000;
        rx_flt = 2'h0;
    end
    // Sends one frame every period+1 cycles; between frames the data lines keep toggling.
    always @(posedge clock) begin
        cnt <= (cnt >= period) ? 8'h00 : cnt + 8'h01;
        rx_valid <= en && (cnt >= period);
        if (en && cnt >= period) begin
            rx_inputs <= img;
            rx_flt <= flt;
        end else begin
            rx_inputs <= ~rx_inputs;
            rx_flt <= ~rx_flt;
        end
    end
endmodule
`default_nettype wire

// ==== test_exm_monitor.sv ====
// Self-checking testbench of the expansion and serial link monitor.
`timescale 1ns/1ns
`default_nettype none
`include "exm_consts.vh"
`define CHK(got, want) begin n_compared++; if ((got) !== (want)) begin fail_count++; \
    $display("ERROR %0t: got %h want %h", $time, got, want); end end
module test_exm_monitor;
    logic clock, rstn, avs_read, avs_write, avs_waitrequest, base_output_group_fault;
    logic [7:0] avs_address, exp_tx_coils;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] base_f;
    logic [4:0] ev;
    logic exp_rx_valid, exp_tx_valid, expansion_not_functional, mfi_discard, link_start_req;
    logic peer_link_diag_bit, conflict, run_mode, p_en;
    logic [11:0] exp_rx_inputs, img;
    logic [1:0] rx_flt, flt;
    logic [15:0] link_data;
    logic [7:0] p_per, co;
    logic [63:0] exq[$];
    logic [63:0] nt;
    int fail_count = 0, n_compared = 0, cyc = 0, g;
    // One cycle per millisecond keeps the long supervision times short.
    localparam int KHZ = 1;
    int mfi_lim[4] = '{`EXM_T_MFI_9K6_MS * KHZ, `EXM_T_MFI_19K2_MS * KHZ,
        `EXM_T_MFI_38K4_MS * KHZ, `EXM_T_MFI_57K6_MS * KHZ};
    int nr_lim[2] = '{`EXM_T_NORESP_9K6_MS * KHZ, `EXM_T_NORESP_19K2_MS * KHZ};
    int crc_lim[2] = '{`EXM_T_CRC_9K6_MS * KHZ, `EXM_T_CRC_19K2_MS * KHZ};
    int t_ol = `EXM_T_EXP_OUT_LOCAL_MS * KHZ, t_or = `EXM_T_EXP_OUT_REMOTE_MS * KHZ;
    exm_monitor #(.CLK_KHZ(KHZ)) dut_u (.clock(clock), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .base_transistor_output(base_f), .base_output_group_fault(base_output_group_fault),
        .exp_rx_valid(exp_rx_valid), .exp_rx_inputs(exp_rx_inputs), .exp_rx_fault_1_4(rx_flt[0]),
        .exp_rx_fault_5_8(rx_flt[1]), .exp_tx_valid(exp_tx_valid), .exp_tx_coils(exp_tx_coils),
        .expansion_not_functional(expansion_not_functional), .mfi_start(ev[0]),
        .mfi_char_valid(ev[1]), .mfi_end(ev[2]), .mfi_discard(mfi_discard),
        .link_frame_ok(ev[3]), .link_crc_error(ev[4]), .link_rx_data(link_data),
        .link_start_req(link_start_req), .peer_link_diag_bit(peer_link_diag_bit),
        .module_conflict_diag(conflict), .run_mode(run_mode));
    exm_exp_partner part_u (.clock(clock), .en(p_en), .period(p_per), .img(img), .flt(flt),
        .rx_valid(exp_rx_valid), .rx_inputs(exp_rx_inputs), .rx_flt(rx_flt));
    // Free running clock of 10 ns.
    always #5 clock = ~clock;
    // Ends the run with the counts and the verdict.
    task print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            fail_count++;
            print_verdict;
        end
    end
    // Compares each completed read with the oldest expectation.
    always @(posedge clock) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            nt = exq.pop_front();
            `CHK(avs_readdata & nt[63:32], nt[31:0])
        end
    end
    // One Avalon-MM transfer, held until waitrequest is seen low.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic [31:0] e);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        if (!w) exq.push_back({m, e});
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0, 32'h0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, d_none(), m, e);
    endtask
    function logic [31:0] d_none();
        return 32'h00000000;
    endfunction
    // One-cycle event pulse: 0 start, 1 char, 2 end, 3 good frame, 4 bad frame.
    task pulse(input int k);
        @(posedge clock);
        ev <= 5'h01 << k;
        @(posedge clock);
        ev <= 5'h00;
    endtask
    function logic pick(input int k);
        case (k)
            0: pick = mfi_discard;
            1: pick = peer_link_diag_bit;
            2: pick = link_start_req;
            default: pick = exp_tx_valid;
        endcase
    endfunction
    // Counts cycles until the chosen output is seen high.
    task gap_to(input int k, output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pick(k) !== 1'b1 && n < 5000);
    endtask
    // ********************
    // Main sequence.
    // ********************
    initial begin
        clock = 0; rstn = 0; avs_read = 0; avs_write = 0; avs_address = 8'h00;
        avs_writedata = 32'h0; base_f = 4'h0; ev = 5'h00; conflict = 0; link_data = 16'h0;
        p_en = 0; p_per = 8'h14; img = 12'h000; flt = 2'h0;
        void'($urandom(32'hC3945A36));
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`EXM_REG_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(`EXM_REG_STATUS, 32'hFFFFFFFF, 32'h8);
        wr(`EXM_REG_STATUS, 32'hFFFFFFFF);
        rd(`EXM_REG_STATUS, 32'hFFFFFFFF, 32'h8);
        rd(8'h20, 32'hFFFFFFFF, 32'h0);
        for (int i = 0; i < 6; i++) begin
            base_f <= 4'($urandom);
            @(posedge clock);
            rd(`EXM_REG_STATUS, 32'h1, {31'h0, |base_f});
        end
        for (int k = 0; k < 4; k++) begin
            conflict <= k[0];
            wr(`EXM_REG_CTRL, k[1]);
            rd(`EXM_REG_STATUS, 32'h60, {k[1] & !k[0], k[0], 5'h00});
        end
        img <= 12'($urandom);
        flt <= 2'($urandom);
        p_en <= 1'b1;
        wr(`EXM_REG_CTRL, 32'h10);
        repeat (100) @(posedge clock);
        rd(`EXM_REG_EXP_IN, 32'hFFF, img);
        rd(`EXM_REG_STATUS, 32'hE, {flt, 1'b0});
        co = 8'($urandom);
        wr(`EXM_REG_EXP_OUT, co);
        rd(`EXM_REG_EXP_OUT, 32'hFF, co);
        gap_to(3, g);
        gap_to(3, g);
        `CHK(exp_tx_coils, co)
        `CHK(g >= t_ol - 2 && g <= t_ol + 2, 1'b1)
        p_per <= 8'h3C;
        wr(`EXM_REG_CTRL, 32'h12);
        repeat (400) @(posedge clock);
        rd(`EXM_REG_STATUS, 32'h8, 32'h0);
        gap_to(3, g);
        gap_to(3, g);
        `CHK(g >= t_or - 2 && g <= t_or + 2, 1'b1)
        p_en <= 1'b0;
        repeat (200) @(posedge clock);
        rd(`EXM_REG_EXP_IN, 32'hFFF, 32'h0);
        rd(`EXM_REG_STATUS, 32'hE, 32'h8);
        gap_to(3, g);
        gap_to(3, g);
        `CHK(exp_tx_coils, 8'h00)
        for (int c = 0; c < 4; c++) begin
            wr(`EXM_REG_CTRL, c << 5);
            pulse(1);
            rd(`EXM_REG_MFI_COUNT, 32'hFFFF, 32'h0);
            pulse(0);
            for (int j = 1; j <= 3; j++) begin
                repeat (mfi_lim[c] - 40) @(posedge clock);
                pulse(1);
                if (j == 2) rd(`EXM_REG_MFI_COUNT, 32'hFFFF, 32'h2);
                if (j == 2) rd(`EXM_REG_STATUS, 32'h80, 32'h80);
            end
            gap_to(0, g);
            `CHK(g >= mfi_lim[c] - 2 && g <= mfi_lim[c] + 2, 1'b1)
            rd(`EXM_REG_MFI_COUNT, 32'hFFFF, 32'h0);
            rd(`EXM_REG_STATUS, 32'h80, 32'h0);
        end
        for (int b = 0; b < 2; b++) begin
            wr(`EXM_REG_CTRL, 32'h4 | (b << 3));
            link_data <= 16'($urandom);
            pulse(3);
            rd(`EXM_REG_LINK_RX, 32'hFFFF, link_data);
            rd(`EXM_REG_STATUS, 32'h10, 32'h0);
            gap_to(1, g);
            `CHK(g >= nr_lim[b] - 12 && g <= nr_lim[b] + 2, 1'b1)
            repeat (2) @(posedge clock);
            gap_to(2, g);
            `CHK(g >= nr_lim[b] - 4 && g <= nr_lim[b] + 2, 1'b1)
            rd(`EXM_REG_LINK_RX, 32'hFFFF, 32'h0);
            rd(`EXM_REG_STATUS, 32'h10, 32'h10);
            pulse(3);
            pulse(4);
            gap_to(1, g);
            `CHK(g >= crc_lim[b] - 2 && g <= crc_lim[b] + 2, 1'b1)
            pulse(3);
        end
        wr(`EXM_REG_CTRL, 32'h0);
        repeat (400) @(posedge clock);
        rd(`EXM_REG_STATUS, 32'h10, 32'h0);
        rd(`EXM_REG_LINK_RX, 32'hFFFF, 32'h0);
        repeat (4) @(posedge clock);
        print_verdict;
    end
endmodule
bind exm_monitor exm_monitor_props chk_u (.clock, .rstn, .avs_read, .avs_write,
    .avs_waitrequest, .base_transistor_output, .base_output_group_fault, .exp_rx_valid,
    .exp_tx_valid, .exp_tx_coils, .expansion_not_functional, .mfi_char_valid, .mfi_discard,
    .link_frame_ok, .link_start_req, .peer_link_diag_bit, .module_conflict_diag, .run_mode);
`default_nettype wire
